// File: chg_asserts.sv
// Wire-level checks on the two-wire bus between master and charger ends
`timescale 1ns/1ns
module chg_asserts #(
  parameter int FS_QTR = 63
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [15:0] lo_cnt;
  logic [15:0] next_lo_cnt;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Length of the current clock-low phase
  always_comb begin
    next_lo_cnt = scl ? 16'h0000 : lo_cnt + 16'h0001;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lo_cnt <= 16'h0000;
    end else begin
      lo_cnt <= next_lo_cnt;
    end
  end
  a_release_idle: assert property ($fell(rst_i) |-> !host_sda_oe && !dev_sda_oe && scl)
    else $error("bus not idle after reset");
  a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("slave data moved while clock high");
  a_ack_holds: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("slave low bit too short");
  a_no_clash: assert property (scl |-> !(dev_sda_oe && host_sda_oe))
    else $error("both ends drive data while clock high");
  a_stop_frees: assert property ($rose(sda) && scl |=> !dev_sda_oe [*8])
    else $error("slave drives after stop");
  a_stop_scl_high: assert property ($rose(sda) && scl |-> scl [*8])
    else $error("clock moved right after stop");
  a_start_clocks: assert property ($fell(sda) && scl |-> ##[1:400] !scl)
    else $error("no clock after start");
  a_scl_low_bound: assert property (lo_cnt < 4 * FS_QTR)
    else $error("clock held low too long");
  c_ack: cover property ($rose(dev_sda_oe));
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
endmodule

// File: chg_dev.sv
// Charger end: two-wire slave with status, control and voltage registers
// Summary of operation
// - Answer only seven-bit address 6B.
// - Detect start and stop while clock high.
// - After stop, idle until start plus address.
// - Data changes only while clock low.
// - Matching address acknowledged on ninth clock.
// - Receiver acknowledges every byte; master leaves its read byte unacknowledged.
// - Unmapped register reads return FF.
// - Master stops to abandon a transfer.
// - Master code unacknowledged, enables high speed.
// - Stop returns slave to normal speed.
// - Normal speeds both ways; high speed writes.
// - Status bit 7 kicks watchdog, reads source-select.
// - Status bit 6 enables charge indication.
// - Status bits 5:3 show state, boost.
// - Status bits 2:0 show fault code.
// - Control bits 7:6 set input limit outside default mode.
// - Control bits 5:4 set accessory limit.
// - Control bit 3 enables termination.
// - Control bit 2 disables charging.
// - Control bits 1:0 high-impedance, accessory on.
// - Voltage bits 7:2, 20 mV steps.
// - High impedance overrides boost selection.
`timescale 1ns/1ns
module chg_dev
  import chg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  chg_if.dev bus,
  input wire logic psel_i,
  input wire logic default_mode_i,
  input wire logic charge_or_boost_select_i,
  input wire logic [1:0] charge_progress_code_i,
  input wire logic [2:0] fault_code_i,
  output logic watchdog_kick_o,
  output logic stat_enable_o,
  output logic [1:0] in_limit_o,
  output logic [1:0] accessory_out_limit_o,
  output logic end_of_charge_cutoff_on_o,
  output logic charge_disable_o,
  output logic high_impedance_o,
  output logic accessory_out_on_o,
  output logic boost_active_o,
  output logic [5:0] battery_target_voltage_o,
  output logic hs_mode_o
);
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] psel_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  chg_slv_st_t st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [7:0] ptr, next_ptr;
  logic rw, next_rw;
  logic hs, next_hs;
  logic nack, next_nack;
  logic sda_oe, next_sda_oe;
  logic kick, next_kick;
  logic stat_en, next_stat_en;
  logic [7:0] ctrl, next_ctrl;
  logic [5:0] vreg, next_vreg;
  logic [1:0] lim, next_lim;
  logic boost, next_boost;
  logic [7:0] rd_val;

  // Edges seen only on the second and third sync stages
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_c = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop_c = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  always_comb begin
    case (ptr)
      CHG_REG_STATUS: rd_val = {psel_q[1], stat_en, charge_progress_code_i, boost,
                                fault_code_i};
      CHG_REG_CTRL: rd_val = ctrl;
      CHG_REG_VREG: rd_val = {vreg, 2'h0};
      default: rd_val = CHG_UNMAPPED;
    endcase
  end

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_ptr = ptr;
    next_rw = rw;
    next_hs = hs;
    next_nack = nack;
    next_sda_oe = sda_oe;
    next_kick = 1'b0;
    next_stat_en = stat_en;
    next_ctrl = ctrl;
    next_vreg = vreg;
    if (stop_c) begin
      next_st = CHG_S_IDLE;
      next_sda_oe = 1'b0;
      next_hs = 1'b0;
    end else if (start_c) begin
      next_st = CHG_S_ADDR;
      next_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (scl_rise) begin
      // Sampling on the rising edge relies on data stable while clock high
      if (st == CHG_S_RACK) begin
        next_nack = sda_q[1];
      end else if (st == CHG_S_ADDR || st == CHG_S_REG || st == CHG_S_WDATA) begin
        next_sh = {sh[6:0], sda_q[1]};
        next_cnt = cnt + 4'h1;
      end
    end else if (scl_fall) begin
      unique case (st)
        CHG_S_IDLE: begin
        end
        CHG_S_ADDR: begin
          if (cnt == CHG_BYTE_BITS) begin
            if (sh[7:3] == CHG_MC_PREFIX) begin
              next_hs = 1'b1;
              next_st = CHG_S_IDLE;
            end else if (sh[7:1] == CHG_DEV_ADDR && !(hs && sh[0])) begin
              next_sda_oe = 1'b1;
              next_rw = sh[0];
              next_st = CHG_S_ADDR_ACK;
            end else begin
              next_st = CHG_S_IDLE;
            end
          end
        end
        CHG_S_ADDR_ACK: begin
          next_cnt = 4'h0;
          if (rw) begin
            next_sh = rd_val;
            next_sda_oe = ~rd_val[7];
            next_st = CHG_S_RDATA;
          end else begin
            next_sda_oe = 1'b0;
            next_st = CHG_S_REG;
          end
        end
        CHG_S_REG: begin
          if (cnt == CHG_BYTE_BITS) begin
            next_ptr = sh;
            next_sda_oe = 1'b1;
            next_st = CHG_S_REG_ACK;
          end
        end
        CHG_S_WDATA: begin
          if (cnt == CHG_BYTE_BITS) begin
            next_sda_oe = 1'b1;
            next_st = CHG_S_WACK;
            next_ptr = ptr + 8'h01;
            case (ptr)
              CHG_REG_STATUS: begin
                next_kick = sh[CHG_KICK_BIT];
                next_stat_en = sh[CHG_STATEN_BIT];
              end
              CHG_REG_CTRL: next_ctrl = sh;
              CHG_REG_VREG: next_vreg = sh[CHG_VREG_HI:CHG_VREG_LO];
              default: begin
              end
            endcase
          end
        end
        CHG_S_REG_ACK, CHG_S_WACK: begin
          next_sda_oe = 1'b0;
          next_cnt = 4'h0;
          next_st = CHG_S_WDATA;
        end
        CHG_S_RDATA: begin
          if (cnt == CHG_LAST_BIT) begin
            next_sda_oe = 1'b0;
            next_ptr = ptr + 8'h01;
            next_st = CHG_S_RACK;
          end else begin
            next_sh = {sh[6:0], 1'b0};
            next_sda_oe = ~sh[6];
            next_cnt = cnt + 4'h1;
          end
        end
        CHG_S_RACK: begin
          next_cnt = 4'h0;
          if (nack) begin
            next_st = CHG_S_IDLE;
          end else begin
            next_sh = rd_val;
            next_sda_oe = ~rd_val[7];
            next_st = CHG_S_RDATA;
          end
        end
      endcase
    end
  end

  // Input limit follows source-select while in default mode
  always_comb begin
    if (default_mode_i) begin
      next_lim = psel_q[1] ? CHG_LIM_500MA : CHG_LIM_100MA;
    end else begin
      next_lim = ctrl[CHG_ILIM_HI:CHG_ILIM_LO];
    end
    next_boost = charge_or_boost_select_i & ~ctrl[CHG_HIZ_BIT];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      psel_q <= 2'h0;
      st <= CHG_S_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      hs <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
      kick <= 1'b0;
      stat_en <= CHG_STATEN_RST;
      ctrl <= CHG_CTRL_RST;
      vreg <= CHG_VREG_RST;
      lim <= CHG_LIM_100MA;
      boost <= 1'b0;
    end else begin
      scl_q <= {scl_q[1:0], bus.scl};
      sda_q <= {sda_q[1:0], bus.sda};
      psel_q <= {psel_q[0], psel_i};
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      ptr <= next_ptr;
      rw <= next_rw;
      hs <= next_hs;
      nack <= next_nack;
      sda_oe <= next_sda_oe;
      kick <= next_kick;
      stat_en <= next_stat_en;
      ctrl <= next_ctrl;
      vreg <= next_vreg;
      lim <= next_lim;
      boost <= next_boost;
    end
  end

  assign bus.dev_sda_oe = sda_oe;
  assign watchdog_kick_o = kick;
  assign stat_enable_o = stat_en;
  assign in_limit_o = lim;
  assign accessory_out_limit_o = ctrl[CHG_ACC_HI:CHG_ACC_LO];
  assign end_of_charge_cutoff_on_o = ctrl[CHG_TERM_BIT];
  assign charge_disable_o = ctrl[CHG_CDIS_BIT];
  assign high_impedance_o = ctrl[CHG_HIZ_BIT];
  assign accessory_out_on_o = ctrl[CHG_ACC_ON_BIT];
  assign boost_active_o = boost;
  assign battery_target_voltage_o = vreg;
  assign hs_mode_o = hs;
endmodule

// File: chg_host.sv
// Master end: runs one register write or read over the two-wire bus
`timescale 1ns/1ns
module chg_host
  import chg_pkg::*;
#(
  parameter int FS_QTR = CHG_FS_QTR,
  parameter int HS_QTR = CHG_HS_QTR
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  chg_if.host bus,
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic cmd_hs_i,
  input wire logic [7:0] cmd_reg_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rdata_o
);
  localparam logic [7:0] FS_RELOAD = 8'(FS_QTR - 1);
  localparam logic [7:0] HS_RELOAD = 8'(HS_QTR - 1);
  localparam logic [7:0] RD_IDLE = 8'hFF;

  logic [1:0] sda_q;
  chg_hst_st_t hst, next_hst;
  chg_step_t step, next_step;
  logic [1:0] ph, next_ph;
  logic [7:0] qcnt, next_qcnt;
  logic [3:0] bitn, next_bitn;
  logic [7:0] tx, next_tx;
  logic [7:0] rx, next_rx;
  logic ackbit, next_ackbit;
  logic hs, next_hs;
  logic rd, next_rd;
  logic [7:0] reg_a, next_reg_a;
  logic [7:0] wdat, next_wdat;
  logic scl_oe, next_scl_oe;
  logic sda_oe, next_sda_oe;
  logic ready, next_ready;
  logic done, next_done;
  logic nack, next_nack;
  logic [7:0] rdata, next_rdata;

  function automatic logic [7:0] byte_of(input chg_step_t s, input logic [7:0] r,
                                         input logic [7:0] d);
    unique case (s)
      CHG_T_MC: byte_of = CHG_MC_BYTE;
      CHG_T_AW: byte_of = {CHG_DEV_ADDR, 1'b0};
      CHG_T_REG: byte_of = r;
      CHG_T_WD: byte_of = d;
      CHG_T_AR: byte_of = {CHG_DEV_ADDR, 1'b1};
      CHG_T_RD: byte_of = RD_IDLE;
    endcase
  endfunction

  always_comb begin
    next_hst = hst;
    next_step = step;
    next_ph = ph;
    next_qcnt = qcnt;
    next_bitn = bitn;
    next_tx = tx;
    next_rx = rx;
    next_ackbit = ackbit;
    next_hs = hs;
    next_rd = rd;
    next_reg_a = reg_a;
    next_wdat = wdat;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_ready = ready;
    next_done = 1'b0;
    next_nack = nack;
    next_rdata = rdata;
    if (hst == CHG_H_IDLE) begin
      if (cmd_valid_i) begin
        next_rd = cmd_read_i;
        next_reg_a = cmd_reg_i;
        next_wdat = cmd_data_i;
        next_ready = 1'b0;
        next_nack = 1'b0;
        next_step = cmd_hs_i ? CHG_T_MC : CHG_T_AW;
        next_hst = CHG_H_START;
        next_ph = 2'h0;
        next_qcnt = FS_RELOAD;
      end
    end else if (qcnt != 8'h00) begin
      next_qcnt = qcnt - 8'h01;
    end else begin
      next_qcnt = hs ? HS_RELOAD : FS_RELOAD;
      next_ph = ph + 2'h1;
      unique case (hst)
        CHG_H_START: begin
          unique case (ph)
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b1;
            2'h3: begin
              next_scl_oe = 1'b1;
              next_hst = CHG_H_BIT;
              next_bitn = 4'h0;
              next_tx = byte_of(step, reg_a, wdat);
            end
          endcase
        end
        CHG_H_BIT: begin
          unique case (ph)
            2'h0: next_sda_oe = (bitn < CHG_BYTE_BITS) && (step != CHG_T_RD) && !tx[7];
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              if (bitn < CHG_BYTE_BITS) begin
                next_rx = {rx[6:0], sda_q[1]};
              end else begin
                next_ackbit = sda_q[1];
              end
            end
            2'h3: begin
              next_scl_oe = 1'b1;
              next_bitn = 4'h0;
              if (bitn < CHG_BYTE_BITS) begin
                next_bitn = bitn + 4'h1;
                next_tx = {tx[6:0], 1'b0};
              end else begin
                next_hst = CHG_H_STOP;
                unique case (step)
                  CHG_T_MC: begin
                    next_hs = 1'b1;
                    next_step = CHG_T_AW;
                    next_hst = CHG_H_START;
                  end
                  CHG_T_AW, CHG_T_AR: begin
                    next_nack = ackbit;
                    if (!ackbit) begin
                      next_step = (step == CHG_T_AW) ? CHG_T_REG : CHG_T_RD;
                      next_hst = CHG_H_BIT;
                      next_tx = (step == CHG_T_AW) ? reg_a : RD_IDLE;
                    end
                  end
                  CHG_T_REG: begin
                    next_nack = ackbit;
                    if (!ackbit && rd) begin
                      next_step = CHG_T_AR;
                      next_hst = CHG_H_START;
                    end else if (!ackbit) begin
                      next_step = CHG_T_WD;
                      next_hst = CHG_H_BIT;
                      next_tx = wdat;
                    end
                  end
                  CHG_T_WD: next_nack = ackbit;
                  CHG_T_RD: next_rdata = rx;
                endcase
              end
            end
          endcase
        end
        CHG_H_STOP: begin
          unique case (ph)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0;
            2'h3: begin
              next_hst = CHG_H_IDLE;
              next_hs = 1'b0;
              next_ready = 1'b1;
              next_done = 1'b1;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sda_q <= 2'h3;
      hst <= CHG_H_IDLE;
      step <= CHG_T_AW;
      ph <= 2'h0;
      qcnt <= 8'h00;
      bitn <= 4'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      ackbit <= 1'b0;
      hs <= 1'b0;
      rd <= 1'b0;
      reg_a <= 8'h00;
      wdat <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      ready <= 1'b1;
      done <= 1'b0;
      nack <= 1'b0;
      rdata <= 8'h00;
    end else begin
      sda_q <= {sda_q[0], bus.sda};
      hst <= next_hst;
      step <= next_step;
      ph <= next_ph;
      qcnt <= next_qcnt;
      bitn <= next_bitn;
      tx <= next_tx;
      rx <= next_rx;
      ackbit <= next_ackbit;
      hs <= next_hs;
      rd <= next_rd;
      reg_a <= next_reg_a;
      wdat <= next_wdat;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      ready <= next_ready;
      done <= next_done;
      nack <= next_nack;
      rdata <= next_rdata;
    end
  end

  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_oe = sda_oe;
  assign cmd_ready_o = ready;
  assign done_o = done;
  assign nack_o = nack;
  assign rdata_o = rdata;
endmodule

// File: chg_if.sv
// Two-wire open-drain bus joining master and charger slave
`timescale 1ns/1ns
interface chg_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Pull-ups: a line is low while any party enables its driver
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport dev (input scl, input sda, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface

// File: chg_pkg.sv
// Shared constants and types for the charger serial register port
package chg_pkg;
  localparam logic [6:0] CHG_DEV_ADDR = 7'h6B;
  localparam logic [4:0] CHG_MC_PREFIX = 5'h01;
  localparam logic [7:0] CHG_MC_BYTE = 8'h08;
  localparam logic [7:0] CHG_REG_STATUS = 8'h00;
  localparam logic [7:0] CHG_REG_CTRL = 8'h01;
  localparam logic [7:0] CHG_REG_VREG = 8'h02;
  localparam logic [7:0] CHG_UNMAPPED = 8'hFF;
  localparam logic [7:0] CHG_CTRL_RST = 8'h30;
  localparam logic [5:0] CHG_VREG_RST = 6'h05;
  localparam logic CHG_STATEN_RST = 1'b1;
  localparam int CHG_KICK_BIT = 7;
  localparam int CHG_STATEN_BIT = 6;
  localparam int CHG_ILIM_HI = 7;
  localparam int CHG_ILIM_LO = 6;
  localparam int CHG_ACC_HI = 5;
  localparam int CHG_ACC_LO = 4;
  localparam int CHG_TERM_BIT = 3;
  localparam int CHG_CDIS_BIT = 2;
  localparam int CHG_HIZ_BIT = 1;
  localparam int CHG_ACC_ON_BIT = 0;
  localparam int CHG_VREG_HI = 7;
  localparam int CHG_VREG_LO = 2;
  localparam logic [1:0] CHG_LIM_100MA = 2'h0;
  localparam logic [1:0] CHG_LIM_500MA = 2'h1;
  localparam logic [3:0] CHG_BYTE_BITS = 4'h8;
  localparam logic [3:0] CHG_LAST_BIT = 4'h7;
  // Bit rates and the quarter-period of the master clock, rounded up
  localparam int CHG_CLK_HZ = 25_000_000;
  localparam int CHG_FS_HZ = 100_000;
  localparam int CHG_HS_HZ = 3_400_000;
  localparam int CHG_MIN_QTR = 4;
  localparam int CHG_FS_QTR = (CHG_CLK_HZ + 4 * CHG_FS_HZ - 1) / (4 * CHG_FS_HZ);
  localparam int CHG_HS_QTR_RAW = (CHG_CLK_HZ + 4 * CHG_HS_HZ - 1) / (4 * CHG_HS_HZ);
  localparam int CHG_HS_QTR = (CHG_HS_QTR_RAW < CHG_MIN_QTR) ? CHG_MIN_QTR : CHG_HS_QTR_RAW;
  typedef enum logic [3:0] {
    CHG_S_IDLE, CHG_S_ADDR, CHG_S_ADDR_ACK, CHG_S_REG, CHG_S_REG_ACK,
    CHG_S_WDATA, CHG_S_WACK, CHG_S_RDATA, CHG_S_RACK
  } chg_slv_st_t;
  typedef enum logic [1:0] {CHG_H_IDLE, CHG_H_START, CHG_H_BIT, CHG_H_STOP} chg_hst_st_t;
  typedef enum logic [2:0] {CHG_T_MC, CHG_T_AW, CHG_T_REG, CHG_T_WD, CHG_T_AR, CHG_T_RD} chg_step_t;
endpackage

// File: testbench.sv
// Self-checking bench: master and charger ends joined, plus a hand-driven bus
`timescale 1ns/1ns
module testbench;
  import chg_pkg::*;
  localparam int Q = 12;
  // Quarter of the hand-driven link clock: 320 ns period
  localparam int QB = 2;
  logic clk_sys_i = 0;
  logic rst_i = 1;
  logic psel, dmode, sel, cv, crd, chs, rdy, done, nack, kick, sten, eoc, cdis, hiz, accon, boost;
  logic hs, hs_seen;
  logic [1:0] prog, ilim, alim;
  logic [2:0] flt;
  logic [7:0] creg, cdat, rdat;
  logic [5:0] vt, vt_b;
  logic [9:0] n;
  logic [9:0] notes[$];
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int kicks = 0;
  chg_if u_chg_if();
  chg_if u_chg_if_b();
  chg_dev u_chg_dev(.clk_sys_i, .rst_i, .bus(u_chg_if.dev), .psel_i(psel), .default_mode_i(dmode),
    .charge_or_boost_select_i(sel), .charge_progress_code_i(prog), .fault_code_i(flt),
    .watchdog_kick_o(kick), .stat_enable_o(sten), .in_limit_o(ilim), .accessory_out_limit_o(alim),
    .end_of_charge_cutoff_on_o(eoc), .charge_disable_o(cdis), .high_impedance_o(hiz),
    .accessory_out_on_o(accon), .boost_active_o(boost), .battery_target_voltage_o(vt),
    .hs_mode_o(hs));
  chg_dev u_chg_dev_b(.clk_sys_i, .rst_i, .bus(u_chg_if_b.dev), .psel_i(psel),
    .default_mode_i(dmode), .charge_or_boost_select_i(sel), .charge_progress_code_i(prog),
    .fault_code_i(flt), .watchdog_kick_o(), .stat_enable_o(), .in_limit_o(),
    .accessory_out_limit_o(), .end_of_charge_cutoff_on_o(), .charge_disable_o(),
    .high_impedance_o(), .accessory_out_on_o(), .boost_active_o(),
    .battery_target_voltage_o(vt_b), .hs_mode_o());
  chg_host #(.FS_QTR(Q)) u_chg_host(.clk_sys_i, .rst_i, .bus(u_chg_if.host), .cmd_valid_i(cv),
    .cmd_read_i(crd), .cmd_hs_i(chs), .cmd_reg_i(creg), .cmd_data_i(cdat), .cmd_ready_o(rdy),
    .done_o(done), .nack_o(nack), .rdata_o(rdat));
  chg_asserts #(.FS_QTR(Q)) u_chg_asserts(.clk_sys_i, .rst_i,
    .host_scl_oe(u_chg_if.host_scl_oe), .host_sda_oe(u_chg_if.host_sda_oe),
    .dev_sda_oe(u_chg_if.dev_sda_oe), .scl(u_chg_if.scl), .sda(u_chg_if.sda));
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_sim();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk_sys_i);
    #2;
  endtask
  // One master command; the expected outcome goes on the note queue
  task automatic xfer(logic rd, logic h, logic [7:0] r, logic [7:0] d, logic cd, logic en,
                      logic [7:0] ed);
    notes.push_back({cd, en, ed});
    {cv, crd, chs, creg, cdat} = {1'b1, rd, h, r, d};
    tick(1);
    cv = 0;
    for (int i = 0; i < 20000 && done !== 1'b1; i++) tick(1);
    tick(1);
    check("ready", 8'(rdy), 8'h01);
  endtask
  // Hand-driven bit on the second bus; returns data seen mid-high
  task automatic bb(logic b, output logic s);
    u_chg_if_b.host_sda_oe = ~b;
    tick(QB);
    u_chg_if_b.host_scl_oe = 0;
    tick(QB);
    s = u_chg_if_b.sda;
    tick(QB);
    u_chg_if_b.host_scl_oe = 1;
    tick(QB);
  endtask
  task automatic bb_byte(logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bb(v[i], s);
    bb(1'b1, ack);
  endtask
  task automatic bb_edge(logic stop);
    u_chg_if_b.host_sda_oe = 1;
    tick(QB);
    u_chg_if_b.host_scl_oe = !stop;
    tick(QB);
    u_chg_if_b.host_sda_oe = !stop;
    tick(2 * QB);
  endtask
  always @(negedge clk_sys_i) begin
    if (kick === 1'b1) kicks++;
    if (hs === 1'b1) hs_seen = 1;
    if (done === 1'b1) begin
      n = notes.pop_front();
      check("nack", nack, n[8]);
      if (n[9]) check("rdata", rdat, n[7:0]);
    end
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    logic a;
    logic [7:0] v;
    {psel, dmode, sel, prog, flt, hs_seen} = '0;
    {cv, crd, chs, creg, cdat} = '0;
    {u_chg_if_b.host_scl_oe, u_chg_if_b.host_sda_oe} = 2'b00;
    void'($urandom(18203));
    tick(12);
    rst_i = 0;
    tick(4);
    check("ctrl out", {ilim, alim, eoc, cdis, hiz, accon}, CHG_CTRL_RST);
    check("stat en", sten, 1'b1);
    xfer(1, 0, CHG_REG_CTRL, 8'h00, 1, 0, 8'h30);
    xfer(1, 0, CHG_REG_VREG, 8'h00, 1, 0, 8'h14);
    for (int i = 0; i < 4; i++) begin
      v = {2'(i), 2'(3 - i), 4'($urandom)};
      xfer(0, 0, CHG_REG_CTRL, v, 0, 0, 8'h00);
      tick(3);
      check("ctrl out", {ilim, alim, eoc, cdis, hiz, accon}, v);
      xfer(1, 0, CHG_REG_CTRL, 8'h00, 1, 0, v);
    end
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        v = 8'h02;
        xfer(0, 0, CHG_REG_CTRL, v, 0, 0, 8'h00);
      end
      {psel, sel, prog, flt} = {k[0], k[0], 2'(k >> 1), 3'(7 - k)};
      tick(4);
      check("boost", boost, sel & ~v[1]);
      xfer(1, 0, CHG_REG_STATUS, 8'h00, 1, 0, {psel, 1'b1, prog, sel & ~v[1], flt});
    end
    psel = 0;
    xfer(0, 0, CHG_REG_STATUS, 8'h80, 0, 0, 8'h00);
    check("kick count", 8'(kicks), 8'h01);
    check("stat en", sten, 1'b0);
    xfer(1, 0, CHG_REG_STATUS, 8'h00, 1, 0, {2'b00, prog, 1'b0, flt});
    v = 8'($urandom);
    xfer(0, 0, CHG_REG_VREG, v, 0, 0, 8'h00);
    check("vreg out", vt, v[7:2]);
    xfer(0, 0, 8'h09, 8'h55, 0, 0, 8'h00);
    xfer(1, 0, 8'h09, 8'h00, 1, 0, 8'hFF);
    dmode = 1;
    for (int p = 1; p >= 0; p--) begin
      psel = p[0];
      tick(5);
      check("in limit", ilim, p[0] ? CHG_LIM_500MA : CHG_LIM_100MA);
    end
    xfer(0, 1, CHG_REG_VREG, 8'hA8, 0, 0, 8'h00);
    check("hs seen", hs_seen, 1'b1);
    check("hs off", hs, 1'b0);
    xfer(1, 0, CHG_REG_VREG, 8'h00, 1, 0, 8'hA8);
    xfer(1, 1, CHG_REG_VREG, 8'h00, 0, 1, 8'h00);
    bb_edge(0);
    bb_byte(8'hD4, a);
    check("other addr ack", a, 1'b1);
    bb_edge(1);
    bb_edge(0);
    bb_byte(8'hF6, a);
    check("ten-bit ack", a, 1'b1);
    bb_edge(1);
    bb_edge(0);
    bb_byte(8'hD6, a);
    check("addr ack", a, 1'b0);
    repeat (3) bb(1'b1, a);
    bb_edge(1);
    bb_edge(0);
    bb_byte(8'hD6, a);
    check("ack after abort", a, 1'b0);
    bb_byte(CHG_REG_VREG, a);
    bb_byte(8'h5C, a);
    check("data ack", a, 1'b0);
    bb_edge(1);
    check("vreg b", vt_b, 6'h17);
    end_sim();
  end
endmodule
